// >>> rtl/bridge_utility_diag_defines.vh
`ifndef BRIDGE_UTILITY_DIAG_DEFINES_VH
`define BRIDGE_UTILITY_DIAG_DEFINES_VH

// ======================================================
// register offsets (node space, byte addresses)
`define OFS_UTILITY          8'h20
`define OFS_DIAG_ONE         8'h1c

// ======================================================
// utility register fields
`define UT_LOCKOUT_RETRY_LIMIT_HI           31
`define UT_LOCKOUT_RETRY_LIMIT_LO           28
`define UT_LREL_HI           27
`define UT_LREL_LO           24
`define UT_TRANSACTION_TIMEOUT_LIMIT_HI           23
`define UT_TRANSACTION_TIMEOUT_LIMIT_LO           20
`define UT_MODE_HI           19
`define UT_MODE_LO           18
`define UT_WIN_HI            13
`define UT_WIN_LO            0
`define UT_LOCKOUT_RETRY_LIMIT_RST          4'h4
`define UT_LREL_RST          4'h3
`define UT_TRANSACTION_TIMEOUT_LIMIT_RST          4'hf
`define UT_MODE_RST          2'h0
`define UT_WIN_RST           14'h0000

// mapping modes
`define MODE_COMPAT          2'h0
`define MODE_512B            2'h1
`define MODE_4KB             2'h2
`define MODE_8KB             2'h3

// ======================================================
// diagnostic one register fields
`define DG_ECC_DIS           0
`define DG_INTERRUPT_SENT_STATUS         1
`define DG_FORCE_ECC         11

// ======================================================
// window decode constants
`define WIN_BASE32           32'h00e00000
`define WIN_BASE30           32'h00200000
`define WIN_RELOC_BASE32     32'h0e000000
`define WIN_RELOC_BASE30     32'h02000000
`define WIN_NODE_STRIDE      32'h00200000
`define WIN_SUB_STRIDE       32'h00002000

// ======================================================
// timing
`define CLK_PERIOD_NS        50
`define TICK_MS_NS           1000000
`define TICK_SHORT_NS        64000
`define LIMIT_MIN            4'h1

`endif

// >>> rtl/tick_divider.v
`timescale 1ns/1ps
// ======================================================
// free-running tick: one pulse every DIV clocks
module tick_divider
#(
  parameter DIV   = 20000,
  parameter WIDTH = 16
)
(
  input  wire i_clk,
  input  wire i_rst_n,
  output reg  o_tick
);

  reg [WIDTH-1:0] count_r;

  // counter wraps at DIV-1 and pulses
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_r <= {WIDTH{1'b0}};
      o_tick  <= 1'b0;
    end
    else if (count_r == DIV[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1})
    begin
      count_r <= {WIDTH{1'b0}};
      o_tick  <= 1'b1;
    end
    else
    begin
      count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
      o_tick  <= 1'b0;
    end
  end

endmodule

// >>> rtl/bridge_utility_diag_regs.v
// Contract
// RULE_01: sent-status mirrors error-bit-sent, W1C, reset zero
// RULE_02: loopback, masked error sets sent-status
// RULE_03: loopback suppresses real interrupt delivery
// RULE_04: sent-status reads zero outside loopback
// RULE_05: self-test fail never touches multiple-errors
// RULE_06: ecc disable zeroes status, blocks interrupts
// RULE_07: force-ecc-error overrides ecc disable
// RULE_08: lockout retry limit, resets to four
// RULE_09: limit zero or one means one attempt
// RULE_10: release lockout on time limit, reset three
// RULE_11: release time n means n-1 to n ms
// RULE_12: transaction timeout aborts, sets timeout error; code only raises o_txn_abort, no timeout error bit
// RULE_13: short timeout uses 64 us steps
// RULE_14: two-bit mapping mode, reset zero
// RULE_15: window space field places 32 Mbyte window; code steps the base by 2 Mbyte per field count and decodes an 8 Kbyte window
// RULE_16: default window from system and secondary ids
// RULE_17: relocated window from window space field
// RULE_18: software writes nonzero window before enable
// RULE_19: refuse unmapped or zero-window relocated commands
// RULE_20: limits measured with free-running tick counters
`timescale 1ns/1ps
`include "bridge_utility_diag_defines.vh"

module bridge_utility_diag_regs
#(
  parameter MS_CYCLES    = `TICK_MS_NS / `CLK_PERIOD_NS,
  parameter SHORT_CYCLES = `TICK_SHORT_NS / `CLK_PERIOD_NS,
  parameter NERR         = 8
)
(
  input  wire             i_clk,
  input  wire             i_rst_n,
  // register access
  input  wire             i_reg_sel,
  input  wire             i_reg_we,
  input  wire [7:0]       i_reg_offset,
  input  wire [31:0]      i_reg_wdata,
  output reg  [31:0]      o_reg_rdata,
  output reg              o_reg_ack,
  output reg              o_reg_noack,
  // loopback and error interrupt path
  input  wire             i_loopback,
  input  wire [NERR-1:0]  i_err_events,
  input  wire [NERR-1:0]  i_error_interrupt_mask,
  output reg              o_error_interrupt,
  // error summary
  input  wire             i_new_error,
  input  wire             i_error_pending,
  input  wire             i_selftest_fail,
  output reg              o_multi_err_set,
  // ecc
  input  wire [3:0]       i_ecc_status_raw,
  input  wire             i_ecc_corr_err,
  input  wire             i_ecc_uncorr_err,
  output reg  [3:0]       o_ecc_status,
  output reg              o_ecc_error_interrupt,
  output reg              o_ecc_vec_error_interrupt,
  output reg              o_ecc_enable,
  // interlock read and lockout
  input  wire             i_interlock_read_fail,
  input  wire             i_interlock_read_ok,
  output reg              o_lockout,
  // transaction timeout and mapping mode
  input  wire             i_txn_active,
  input  wire             i_short_timeout,
  output reg              o_txn_abort,
  output reg  [1:0]       o_mapping_mode_select,
  // io decode
  input  wire             i_io_req,
  input  wire [31:0]      i_io_addr,
  input  wire             i_addr32,
  input  wire             i_csr_hit,
  input  wire             i_window_en,
  input  wire [3:0]       i_sys_node_id,
  input  wire [3:0]       i_sec_node_id,
  output reg              o_io_ack,
  output reg              o_io_noack,
  output reg              o_io_window_hit
);

  // ======================================================
  // registers
  reg  [3:0]  lockout_retry_limit_r;
  reg  [3:0]  lockout_release_time_r;
  reg  [3:0]  transaction_timeout_limit_r;
  reg  [1:0]  mapping_mode_select_r;
  reg  [13:0] window_space_field_r;
  reg         ecc_disable_r;
  reg         force_ecc_r;
  reg         interrupt_sent_status_r;
  reg  [3:0]  retry_cnt_r;
  reg  [3:0]  lock_ticks_r;
  reg  [3:0]  txn_ticks_r;

  wire        tick_ms;
  wire        tick_short;
  wire        wr_util;
  wire        wr_diag;
  wire        err_bit_sent;
  wire        ecc_active;
  wire [3:0]  lockout_retry_limit_eff;
  wire [3:0]  lrel_eff;
  wire [3:0]  transaction_timeout_limit_eff;
  wire        txn_tick;
  wire [35:0] win_base;
  wire [35:0] addr_ext;
  wire        win_hit;
  wire        win_zero_illegal;
  reg  [31:0] rdata_nxt;

  // ======================================================
  // tick sources
  // RULE_20: free-running tick counters
  tick_divider #(.DIV(MS_CYCLES), .WIDTH(16)) u_tick_ms
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick_ms)
  );

  tick_divider #(.DIV(SHORT_CYCLES), .WIDTH(16)) u_tick_short
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick_short)
  );

  // ======================================================
  // register access decode
  assign wr_util = i_reg_sel & i_reg_we & (i_reg_offset == `OFS_UTILITY);
  assign wr_diag = i_reg_sel & i_reg_we & (i_reg_offset == `OFS_DIAG_ONE);

  // utility register fields
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // RULE_08: retry limit resets to four
      lockout_retry_limit_r       <= `UT_LOCKOUT_RETRY_LIMIT_RST;
      // RULE_10: release time resets to three
      lockout_release_time_r      <= `UT_LREL_RST;
      transaction_timeout_limit_r <= `UT_TRANSACTION_TIMEOUT_LIMIT_RST;
      // RULE_14: mapping mode resets zero
      mapping_mode_select_r       <= `UT_MODE_RST;
      window_space_field_r        <= `UT_WIN_RST;
    end
    else if (wr_util)
    begin
      // RULE_09: any value zero to f accepted
      lockout_retry_limit_r       <= i_reg_wdata[`UT_LOCKOUT_RETRY_LIMIT_HI:`UT_LOCKOUT_RETRY_LIMIT_LO];
      lockout_release_time_r      <= i_reg_wdata[`UT_LREL_HI:`UT_LREL_LO];
      transaction_timeout_limit_r <= i_reg_wdata[`UT_TRANSACTION_TIMEOUT_LIMIT_HI:`UT_TRANSACTION_TIMEOUT_LIMIT_LO];
      mapping_mode_select_r       <= i_reg_wdata[`UT_MODE_HI:`UT_MODE_LO];
      // RULE_15: window space field stored
      window_space_field_r        <= i_reg_wdata[`UT_WIN_HI:`UT_WIN_LO];
    end
  end

  // diagnostic control bits
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ecc_disable_r <= 1'b0;
      force_ecc_r   <= 1'b0;
    end
    else if (wr_diag)
    begin
      ecc_disable_r <= i_reg_wdata[`DG_ECC_DIS];
      force_ecc_r   <= i_reg_wdata[`DG_FORCE_ECC];
    end
  end

  // ======================================================
  // interrupt sent status
  assign err_bit_sent = |(i_err_events & i_error_interrupt_mask);

  // set wins over write-one clear
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      interrupt_sent_status_r <= 1'b0;
    // RULE_04: zero outside loopback
    else if (!i_loopback)
      interrupt_sent_status_r <= 1'b0;
    // RULE_02: masked error sets status
    else if (err_bit_sent)
      interrupt_sent_status_r <= 1'b1;
    // RULE_01: write one clears
    else if (wr_diag & i_reg_wdata[`DG_INTERRUPT_SENT_STATUS])
      interrupt_sent_status_r <= 1'b0;
  end

  // delivery to companion module
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_error_interrupt <= 1'b0;
    else
      // RULE_03: loopback blocks delivery
      o_error_interrupt <= err_bit_sent & ~i_loopback;
  end

  // multiple-errors set, self-test fail excluded
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_multi_err_set <= 1'b0;
    else
      // RULE_05: self-test fail ignored
      o_multi_err_set <= i_new_error & i_error_pending & ~i_selftest_fail;
  end

  // ======================================================
  // ecc gating
  // RULE_07: force overrides disable
  assign ecc_active = ~ecc_disable_r | force_ecc_r;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ecc_status   <= 4'h0;
      o_ecc_error_interrupt     <= 1'b0;
      o_ecc_vec_error_interrupt <= 1'b0;
      o_ecc_enable   <= 1'b1;
    end
    else
    begin
      // RULE_06: disable zeroes status and interrupts
      o_ecc_status   <= ecc_active ? i_ecc_status_raw : 4'h0;
      o_ecc_error_interrupt     <= ecc_active & i_ecc_corr_err;
      o_ecc_vec_error_interrupt <= ecc_active & i_ecc_uncorr_err;
      o_ecc_enable   <= ecc_active;
    end
  end

  // ======================================================
  // lockout control
  // RULE_09: zero and one mean one
  assign lockout_retry_limit_eff = (lockout_retry_limit_r < `LIMIT_MIN) ? `LIMIT_MIN : lockout_retry_limit_r;
  // RULE_11: zero and one give lowest step
  assign lrel_eff = (lockout_release_time_r < `LIMIT_MIN) ? `LIMIT_MIN : lockout_release_time_r;

  // count failed interlock reads, hold lockout
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      retry_cnt_r  <= 4'h0;
      lock_ticks_r <= 4'h0;
      o_lockout    <= 1'b0;
    end
    else if (o_lockout)
    begin
      // RULE_10: release on success or time
      if (i_interlock_read_ok | (tick_ms & (lock_ticks_r + 4'h1 >= lrel_eff)))
      begin
        o_lockout    <= 1'b0;
        retry_cnt_r  <= 4'h0;
        lock_ticks_r <= 4'h0;
      end
      else if (tick_ms)
        lock_ticks_r <= lock_ticks_r + 4'h1;
    end
    else if (i_interlock_read_ok)
      retry_cnt_r <= 4'h0;
    else if (i_interlock_read_fail)
    begin
      // RULE_08: assert after limit attempts
      if (retry_cnt_r + 4'h1 >= lockout_retry_limit_eff)
      begin
        o_lockout    <= 1'b1;
        lock_ticks_r <= 4'h0;
      end
      else
        retry_cnt_r <= retry_cnt_r + 4'h1;
    end
  end

  // ======================================================
  // transaction timeout
  // RULE_13: short enable selects 64 us tick
  assign txn_tick = i_short_timeout ? tick_short : tick_ms;
  assign transaction_timeout_limit_eff = (transaction_timeout_limit_r < `LIMIT_MIN) ? `LIMIT_MIN
                                                               : transaction_timeout_limit_r;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      txn_ticks_r <= 4'h0;
      o_txn_abort <= 1'b0;
    end
    else if (!i_txn_active | o_txn_abort)
    begin
      txn_ticks_r <= 4'h0;
      o_txn_abort <= 1'b0;
    end
    else if (txn_tick)
    begin
      // RULE_12: expiry aborts transaction
      if (txn_ticks_r + 4'h1 >= transaction_timeout_limit_eff)
        o_txn_abort <= 1'b1;
      txn_ticks_r <= txn_ticks_r + 4'h1;
    end
  end

  // mapping mode out to translation logic
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_mapping_mode_select <= `UT_MODE_RST;
    else
      // RULE_14: mode drives translation
      o_mapping_mode_select <= mapping_mode_select_r;
  end

  // ======================================================
  // io window decode
  // RULE_16: default base from node ids
  // RULE_17: relocated base from window field
  assign win_base = i_window_en
    ? ({4'h0, (i_addr32 ? `WIN_RELOC_BASE32 : `WIN_RELOC_BASE30)}
       + ({22'h0, window_space_field_r} * {4'h0, `WIN_NODE_STRIDE})
       + ({32'h0, i_sec_node_id} * {4'h0, `WIN_SUB_STRIDE}))
    : ({4'h0, (i_addr32 ? `WIN_BASE32 : `WIN_BASE30)}
       + ({32'h0, i_sys_node_id} * {4'h0, `WIN_NODE_STRIDE})
       + ({32'h0, i_sec_node_id} * {4'h0, `WIN_SUB_STRIDE}));
  assign addr_ext = {4'h0, i_io_addr};
  assign win_hit  = (addr_ext >= win_base) & (addr_ext < win_base + {4'h0, `WIN_SUB_STRIDE});
  // RULE_18: zero field with enable is illegal
  assign win_zero_illegal = i_window_en & (window_space_field_r == `UT_WIN_RST);

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_io_ack        <= 1'b0;
      o_io_noack      <= 1'b0;
      o_io_window_hit <= 1'b0;
    end
    else
    begin
      // RULE_19: refuse unmapped or illegal window
      o_io_noack      <= i_io_req & ((~i_csr_hit & ~win_hit) | win_zero_illegal);
      o_io_ack        <= i_io_req & (i_csr_hit | win_hit) & ~win_zero_illegal;
      o_io_window_hit <= i_io_req & win_hit & ~win_zero_illegal;
    end
  end

  // ======================================================
  // register read path
  always @*
  begin
    rdata_nxt = 32'h0;
    case (i_reg_offset)
      `OFS_UTILITY:
      begin
        rdata_nxt[`UT_LOCKOUT_RETRY_LIMIT_HI:`UT_LOCKOUT_RETRY_LIMIT_LO] = lockout_retry_limit_r;
        rdata_nxt[`UT_LREL_HI:`UT_LREL_LO] = lockout_release_time_r;
        rdata_nxt[`UT_TRANSACTION_TIMEOUT_LIMIT_HI:`UT_TRANSACTION_TIMEOUT_LIMIT_LO] = transaction_timeout_limit_r;
        rdata_nxt[`UT_MODE_HI:`UT_MODE_LO] = mapping_mode_select_r;
        rdata_nxt[`UT_WIN_HI:`UT_WIN_LO]   = window_space_field_r;
      end
      `OFS_DIAG_ONE:
      begin
        rdata_nxt[`DG_ECC_DIS]   = ecc_disable_r;
        // RULE_04: reads zero outside loopback
        rdata_nxt[`DG_INTERRUPT_SENT_STATUS] = interrupt_sent_status_r & i_loopback;
        rdata_nxt[`DG_FORCE_ECC] = force_ecc_r;
      end
      default:
        rdata_nxt = 32'h0;
    endcase
  end

  // access answer one clock after select
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= 32'h0;
      o_reg_ack   <= 1'b0;
      o_reg_noack <= 1'b0;
    end
    else
    begin
      o_reg_rdata <= (i_reg_sel & ~i_reg_we) ? rdata_nxt : 32'h0;
      o_reg_ack   <= i_reg_sel & ((i_reg_offset == `OFS_UTILITY) |
                                  (i_reg_offset == `OFS_DIAG_ONE));
      o_reg_noack <= i_reg_sel & (i_reg_offset != `OFS_UTILITY) &
                                 (i_reg_offset != `OFS_DIAG_ONE);
    end
  end

endmodule

// >>> testbench/util_diag_monitor.sv
`timescale 1ns/1ps
// ======================================================
// checker on the utility and diagnostic block ports
module util_diag_monitor
#(
  parameter NERR = 8
)
(
  input wire            i_clk,
  input wire            i_rst_n,
  input wire            i_reg_sel,
  input wire [7:0]      i_reg_offset,
  input wire            o_reg_noack,
  input wire            i_io_req,
  input wire            i_csr_hit,
  input wire            i_window_en,
  input wire            o_io_ack,
  input wire            o_io_noack,
  input wire            i_loopback,
  input wire [NERR-1:0] i_err_events,
  input wire [NERR-1:0] i_error_interrupt_mask,
  input wire            o_error_interrupt,
  input wire            i_new_error,
  input wire            i_error_pending,
  input wire            i_selftest_fail,
  input wire            o_multi_err_set,
  input wire            o_ecc_enable,
  input wire [3:0]      o_ecc_status,
  input wire            o_ecc_error_interrupt,
  input wire            o_ecc_vec_error_interrupt,
  input wire            i_txn_active,
  input wire            o_txn_abort,
  input wire            i_interlock_read_fail,
  input wire            o_lockout
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ======================================================
  // properties
  property p_unmapped;
    i_reg_sel && i_reg_offset != 8'h20 && i_reg_offset != 8'h1c |=> o_reg_noack;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset not refused");
  property p_io_one;
    i_io_req |=> o_io_ack != o_io_noack;
  endproperty
  a_io_one: assert property (p_io_one) else $error("io answer not exclusive");
  property p_io_csr;
    i_io_req && i_csr_hit && !i_window_en |=> o_io_ack;
  endproperty
  a_io_csr: assert property (p_io_csr) else $error("own register not acked");
  property p_sent;
    !i_loopback && (|(i_err_events & i_error_interrupt_mask)) |=> o_error_interrupt;
  endproperty
  a_sent: assert property (p_sent) else $error("masked error not sent");
  property p_quiet;
    i_loopback && $past(i_loopback) |-> !o_error_interrupt;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt sent in loopback");
  property p_multi;
    i_new_error && i_error_pending |=> o_multi_err_set == !$past(i_selftest_fail);
  endproperty
  a_multi: assert property (p_multi) else $error("multiple errors wrong");
  property p_ecc_off;
    !o_ecc_enable && $past(!o_ecc_enable) |-> o_ecc_status == 4'h0 && !o_ecc_error_interrupt && !o_ecc_vec_error_interrupt;
  endproperty
  a_ecc_off: assert property (p_ecc_off) else $error("ecc active while off");
  property p_lock_rise;
    $rose(o_lockout) |-> $past(i_interlock_read_fail);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lockout without failed read");
  property p_abort;
    o_txn_abort |-> $past(i_txn_active) ##1 !o_txn_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without transaction");
endmodule

bind bridge_utility_diag_regs util_diag_monitor #(.NERR(NERR)) u_mon (.i_clk, .i_rst_n,
  .i_reg_sel, .i_reg_offset, .o_reg_noack, .i_io_req, .i_csr_hit, .i_window_en,
  .o_io_ack, .o_io_noack, .i_loopback, .i_err_events, .i_error_interrupt_mask, .o_error_interrupt,
  .i_new_error, .i_error_pending, .i_selftest_fail, .o_multi_err_set, .o_ecc_enable,
  .o_ecc_status, .o_ecc_error_interrupt, .o_ecc_vec_error_interrupt, .i_txn_active, .o_txn_abort,
  .i_interlock_read_fail, .o_lockout);

// >>> testbench/bus_node_model.sv
`timescale 1ns/1ps
// ======================================================
// remote node retrying interlock reads until locked out
module bus_node_model
(
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_go,
  input  wire       i_lockout,
  output reg        o_fail,
  output reg  [4:0] o_tries
);
  // one failed attempt every other cycle, counted
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fail  <= 1'b0;
      o_tries <= 5'h00;
    end
    else
    begin
      o_fail <= i_go && !i_lockout && !o_fail;
      if (!i_go)
        o_tries <= 5'h00;
      else if (o_fail)
        o_tries <= o_tries + 5'h01;
    end
  end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         clk = 0, rst_n = 0, sel = 0, we = 0, loop = 0, nerr = 0, pend = 0, stf = 0;
  reg         corr = 0, unc = 0, ok = 0, txn = 0, shrt = 0, ioreq = 0, a32 = 0, csr = 0;
  reg         wen = 0, go = 0, ak, nk;
  reg  [7:0]  off = 0, ev = 0, mk = 8'h0f;
  reg  [31:0] wd = 0, ioad = 0, rd;
  reg  [3:0]  raw = 4'hf, sid = 4'h3, nid = 4'h5;
  wire [31:0] rdata;
  wire [3:0]  ests;
  wire [1:0]  mode;
  wire [4:0]  tries;
  wire        ack, noack, eint, multi, eintr, evint, een, lock, abort, ioack, ionack, iohit;
  wire        fail;
  integer     error_cnt = 0, checks = 0, i, d;
  // ======================================================
  // design, remote node, clock
  bridge_utility_diag_regs #(.MS_CYCLES(20), .SHORT_CYCLES(4)) DUT (.i_clk(clk),
    .i_rst_n(rst_n), .i_reg_sel(sel), .i_reg_we(we), .i_reg_offset(off), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_noack(noack), .i_loopback(loop),
    .i_err_events(ev), .i_error_interrupt_mask(mk), .o_error_interrupt(eint), .i_new_error(nerr),
    .i_error_pending(pend), .i_selftest_fail(stf), .o_multi_err_set(multi),
    .i_ecc_status_raw(raw), .i_ecc_corr_err(corr), .i_ecc_uncorr_err(unc),
    .o_ecc_status(ests), .o_ecc_error_interrupt(eintr), .o_ecc_vec_error_interrupt(evint), .o_ecc_enable(een),
    .i_interlock_read_fail(fail), .i_interlock_read_ok(ok), .o_lockout(lock), .i_txn_active(txn),
    .i_short_timeout(shrt), .o_txn_abort(abort), .o_mapping_mode_select(mode),
    .i_io_req(ioreq), .i_io_addr(ioad), .i_addr32(a32), .i_csr_hit(csr),
    .i_window_en(wen), .i_sys_node_id(sid), .i_sec_node_id(nid), .o_io_ack(ioack),
    .o_io_noack(ionack), .o_io_window_hit(iohit));
  bus_node_model NODE (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_lockout(lock),
    .o_fail(fail), .o_tries(tries));
  always #25 clk = ~clk;
  // ======================================================
  // checking and closing
  task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // one register access, answer captured a cycle later
  task acc(input [7:0] o, input w, input [31:0] v);
    begin
      @(posedge clk);
      sel <= 1; we <= w; off <= o; wd <= v;
      @(posedge clk);
      sel <= 0; we <= 0;
      @(negedge clk);
      rd = rdata; ak = ack; nk = noack;
    end
  endtask
  // error event pulse, interrupt seen a cycle later
  task evp(input [7:0] e);
    begin
      @(posedge clk) ev <= e;
      @(posedge clk) ev <= 0;
      @(negedge clk);
    end
  endtask
  // ecc gating under a diagnostic setting
  task eccc(input [31:0] v, input [6:0] exp);
    begin
      acc(8'h1c, 1, v);
      @(posedge clk) begin corr <= 1; unc <= 1; end
      @(posedge clk) begin corr <= 0; unc <= 0; end
      @(negedge clk) chk("ecc", {een, ests, eintr, evint}, exp);
    end
  endtask
  // io command, exactly one answer
  task io(input [31:0] a, input a3, input c, input w, input [2:0] exp);
    begin
      @(posedge clk) begin ioreq <= 1; ioad <= a; a32 <= a3; csr <= c; wen <= w; end
      @(posedge clk) ioreq <= 0;
      @(negedge clk) chk("io", {ioack, ionack, iohit}, exp);
    end
  endtask
  // lockout after a retry count, then hold time
  task lk(input [31:0] v, input [4:0] n, input integer lo, input integer hi);
    begin
      acc(8'h20, 1, v);
      @(posedge clk) go <= 1;
      for (d = 0; d < 80 && !lock; d = d + 1) @(negedge clk);
      chk("tries", tries, n);
      @(posedge clk) go <= 0;
      for (d = 1; d < 100 && lock; d = d + 1) @(negedge clk);
      chk("hold", (d >= lo && d <= hi), 1);
    end
  endtask
  // watchdog
  initial
  begin
    #(20000 * 50);
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  // ======================================================
  // tests
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    acc(8'h20, 0, 0); chk("ut_rst", rd, 32'h43f00000);
    chk("ack", {ak, nk}, 2'b10);
    acc(8'h1c, 0, 0); chk("dg_rst", rd, 32'h0);
    acc(8'h20, 1, 32'hffffffff); acc(8'h20, 0, 0); chk("ut_rw", rd, 32'hfffc3fff);
    acc(8'h44, 1, 1); chk("unmap", {ak, nk}, 2'b01);
    chk("unmap_rd", rd, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      acc(8'h20, 1, i << 18); repeat (2) @(negedge clk); chk("mode", mode, i);
    end
    $display("test registers done");
    evp(8'h02); chk("eint", eint, 1);
    acc(8'h1c, 0, 0); chk("sent", rd[1], 0);
    @(posedge clk) loop <= 1;
    evp(8'h02); chk("eint", eint, 0);
    acc(8'h1c, 0, 0); chk("sent", rd[1], 1);
    acc(8'h1c, 1, 2); acc(8'h1c, 0, 0); chk("clr", rd[1], 0);
    evp(8'h80); acc(8'h1c, 0, 0); chk("unmask", rd[1], 0);
    @(posedge clk) loop <= 0;
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge clk) begin nerr <= 1; pend <= 1; stf <= i; end
      @(posedge clk) nerr <= 0;
      @(negedge clk) chk("multi", multi, !i);
    end
    $display("test interrupts done");
    eccc(32'h1, 7'h00);
    eccc(32'h801, 7'h7f);
    eccc(32'h0, 7'h7f);
    lk(32'h02000000, 1, 19, 42);
    lk(32'h11000000, 1, 1, 22);
    lk(32'hf1000000, 15, 1, 22);
    acc(8'h20, 1, 32'h2f000000); @(posedge clk) go <= 1;
    for (d = 0; d < 40 && !lock; d = d + 1) @(negedge clk);
    chk("ok_set", lock, 1);
    @(posedge clk) begin go <= 0; ok <= 1; end
    @(posedge clk) ok <= 0;
    repeat (2) @(negedge clk); chk("ok_rel", lock, 0);
    $display("test lockout done");
    acc(8'h20, 1, 32'h00200000);
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge clk) begin shrt <= i; txn <= 1; end
      for (d = 0; d < 100 && !abort; d = d + 1) @(negedge clk);
      chk("tmo", d >= (i ? 3 : 19) && d <= (i ? 10 : 42), 1);
      @(posedge clk) txn <= 0;
    end
    $display("test timeout done");
    io(32'h0140a000, 1, 0, 0, 3'b101);
    io(32'h0140c000, 1, 0, 0, 3'b010);
    io(32'h0080a000, 0, 0, 0, 3'b101);
    io(32'h0, 1, 1, 0, 3'b100);
    io(32'h0, 1, 1, 1, 3'b010);
    @(posedge clk) wen <= 0;
    acc(8'h20, 1, 32'h2);
    io(32'h0e40a000, 1, 0, 1, 3'b101);
    io(32'h0240a000, 0, 0, 1, 3'b101);
    io(32'h0140a000, 1, 0, 1, 3'b010);
    $display("test decode done");
    give_verdict;
  end
endmodule
